// file: verilog/lrm_pkg.sv
// Package for the regulator interrupt mask and load meter register bank.
// Assumes a byte-wide register port from the serial control front end.
package lrm_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LINREG_IRQ_MASK = 8'h23;
    localparam logic [7:0] ADDR_LOAD_METER_SELECT = 8'h24;
    localparam logic [7:0] ADDR_LOAD_METER_RESULT_HIGH = 8'h25;
    localparam logic [7:0] ADDR_LOAD_METER_RESULT_LOW = 8'h26;
    localparam logic [7:0] ADDR_LINREG_IRQ_FLAGS = 8'h27;
    localparam logic [7:0] ADDR_LINREG_STATUS = 8'h28;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_LR1_PG_FALL = 7;
    localparam int BIT_LR1_PG_RISE = 6;
    localparam int BIT_LR1_OVERCURRENT = 4;
    localparam int BIT_LR0_PG_FALL = 3;
    localparam int BIT_LR0_PG_RISE = 2;
    localparam int BIT_LR0_OVERCURRENT = 0;
    localparam logic [7:0] MASK_WRITABLE = 8'hdd;
    localparam int BIT_SELECT = 0;
    localparam int RESULT_WIDTH = 9;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_SELECT = 8'h00;
    localparam logic [8:0] RST_RESULT = 9'h000;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lrm_bus_s;
    typedef struct packed {
        logic valid;
        logic [8:0] current;
    } lrm_meas_s;
    typedef enum logic [1:0] {
        LRM_IDLE,
        LRM_BUSY
    } lrm_state_e;
endpackage : lrm_pkg

// file: verilog/lrm_top.sv
// Interrupt mask for two linear regulators and a load-current meter.
// Assumes an analog front end that answers a start strobe with a result.
// Behaviour
// - Bit 7 masks regulator 1 power-good fall
// - Bit 6 masks regulator 1 power-good rise
// - Bit 4 masks regulator 1 overcurrent
// - Bit 3 masks regulator 0 power-good fall
// - Bit 2 masks regulator 0 power-good rise
// - Bit 0 masks regulator 0 overcurrent
// - Mask 0 raises interrupt, 1 suppresses
// - Status tracks condition regardless of mask
// - Select bit 0 picks buck 0 or 1
// - Each select write starts a measurement
// - Master selection reports summed phase current in dual-phase mode, its own current otherwise
// - Slave selection reports its own current
// - Result MSB sits in high register bit 0
// - Low eight result bits in low register
`timescale 1ns/1ps
module lrm_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_linreg1_pg,
    input wire logic i_linreg0_pg,
    input wire logic i_linreg1_overcurrent,
    input wire logic i_linreg0_overcurrent,
    input wire logic i_buck_dual_phase,
    output logic o_meas_start,
    output logic o_meas_buck,
    input wire logic i_meas_done,
    input wire logic [8:0] i_meas_current,
    input wire logic [8:0] i_meas_slave_current,
    output logic o_linreg1_pg_irq,
    output logic o_linreg0_pg_irq,
    output logic o_linreg1_overcurrent_irq,
    output logic o_linreg0_overcurrent_irq,
    output logic o_irq
);
    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    lrm_pkg::lrm_bus_s bus;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    logic [7:0] linreg_irq_mask_r;
    logic [7:0] load_meter_select_r;
    logic [8:0] result_r;
    logic [7:0] linreg_irq_flags_r;
    logic [7:0] linreg_irq_flags_nxt;
    logic [7:0] event_set;
    logic [7:0] linreg_status;
    logic [3:0] cond_d_r;
    logic [7:0] rdata_nxt;
    logic wr_mask;
    logic wr_select;
    logic wr_flags;
    lrm_pkg::lrm_state_e state_r;
    lrm_pkg::lrm_meas_s meas;

    assign wr_mask = bus.wr && (bus.addr == lrm_pkg::ADDR_LINREG_IRQ_MASK);
    assign wr_select = bus.wr && (bus.addr == lrm_pkg::ADDR_LOAD_METER_SELECT);
    assign wr_flags = bus.wr && (bus.addr == lrm_pkg::ADDR_LINREG_IRQ_FLAGS);

    // Reserved mask bits read as zero
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            linreg_irq_mask_r <= lrm_pkg::RST_MASK;
        else if (wr_mask)
            linreg_irq_mask_r <= bus.wdata & lrm_pkg::MASK_WRITABLE;
    end

    // Only bit 0 of the selector is stored; the rest read as zero
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            load_meter_select_r <= lrm_pkg::RST_SELECT;
        else if (wr_select)
            load_meter_select_r <= {7'h00, bus.wdata[lrm_pkg::BIT_SELECT]};
    end

    // ------------------------------------------------------------------
    // Load meter
    // ------------------------------------------------------------------
    // A write while busy restarts on the new selection; a stale answer
    // from the aborted run is taken as the fresh one, which is harmless.
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_meas_start <= 1'b0;
        else
            o_meas_start <= wr_select;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_meas_buck <= 1'b0;
        else if (wr_select)
            o_meas_buck <= bus.wdata[lrm_pkg::BIT_SELECT];
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            state_r <= lrm_pkg::LRM_IDLE;
        else
        begin
            case (state_r)
                lrm_pkg::LRM_IDLE:
                    if (wr_select)
                        state_r <= lrm_pkg::LRM_BUSY;
                lrm_pkg::LRM_BUSY:
                    if (i_meas_done && !wr_select)
                        state_r <= lrm_pkg::LRM_IDLE;
                default:
                    state_r <= lrm_pkg::LRM_IDLE;
            endcase
        end
    end

    // Buck 0 is the master in dual-phase mode, buck 1 its slave
    always_comb
    begin
        meas.valid = (state_r == lrm_pkg::LRM_BUSY) && i_meas_done;
        if (i_buck_dual_phase && !o_meas_buck)
            meas.current = 9'(i_meas_current + i_meas_slave_current);
        else
            meas.current = i_meas_current;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            result_r <= lrm_pkg::RST_RESULT;
        else if (meas.valid)
            result_r <= meas.current;
    end

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    assign linreg_status = {4'h0, i_linreg1_pg, i_linreg0_pg,
        i_linreg1_overcurrent, i_linreg0_overcurrent};

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            cond_d_r <= 4'h0;
        else
            cond_d_r <= linreg_status[3:0];
    end

    // Edges are qualified by a mask bit of 0 only
    always_comb
    begin
        event_set = 8'h00;
        event_set[lrm_pkg::BIT_LR1_PG_FALL] = cond_d_r[3] && !i_linreg1_pg
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR1_PG_FALL];
        event_set[lrm_pkg::BIT_LR1_PG_RISE] = !cond_d_r[3] && i_linreg1_pg
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR1_PG_RISE];
        event_set[lrm_pkg::BIT_LR1_OVERCURRENT] = !cond_d_r[1]
            && i_linreg1_overcurrent
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR1_OVERCURRENT];
        event_set[lrm_pkg::BIT_LR0_PG_FALL] = cond_d_r[2] && !i_linreg0_pg
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR0_PG_FALL];
        event_set[lrm_pkg::BIT_LR0_PG_RISE] = !cond_d_r[2] && i_linreg0_pg
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR0_PG_RISE];
        event_set[lrm_pkg::BIT_LR0_OVERCURRENT] = !cond_d_r[0]
            && i_linreg0_overcurrent
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR0_OVERCURRENT];
    end

    // Set wins over a write-one clear in the same cycle
    always_comb
    begin
        linreg_irq_flags_nxt = linreg_irq_flags_r;
        if (wr_flags)
            linreg_irq_flags_nxt = linreg_irq_flags_nxt & ~bus.wdata;
        linreg_irq_flags_nxt = linreg_irq_flags_nxt | event_set;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            linreg_irq_flags_r <= lrm_pkg::RST_FLAGS;
        else
            linreg_irq_flags_r <= linreg_irq_flags_nxt;
    end

    // Flags are only set when unmasked; the mask also gates the output
    // so that masking a pending flag drops the request at once.
    always_comb
    begin
        o_linreg1_pg_irq = (linreg_irq_flags_r[lrm_pkg::BIT_LR1_PG_FALL]
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR1_PG_FALL])
            || (linreg_irq_flags_r[lrm_pkg::BIT_LR1_PG_RISE]
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR1_PG_RISE]);
        o_linreg0_pg_irq = (linreg_irq_flags_r[lrm_pkg::BIT_LR0_PG_FALL]
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR0_PG_FALL])
            || (linreg_irq_flags_r[lrm_pkg::BIT_LR0_PG_RISE]
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR0_PG_RISE]);
        o_linreg1_overcurrent_irq =
            linreg_irq_flags_r[lrm_pkg::BIT_LR1_OVERCURRENT]
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR1_OVERCURRENT];
        o_linreg0_overcurrent_irq =
            linreg_irq_flags_r[lrm_pkg::BIT_LR0_OVERCURRENT]
            && !linreg_irq_mask_r[lrm_pkg::BIT_LR0_OVERCURRENT];
        o_irq = o_linreg1_pg_irq || o_linreg0_pg_irq
            || o_linreg1_overcurrent_irq || o_linreg0_overcurrent_irq;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (bus.addr == lrm_pkg::ADDR_LINREG_IRQ_MASK)
            rdata_nxt = linreg_irq_mask_r;
        else if (bus.addr == lrm_pkg::ADDR_LOAD_METER_SELECT)
            rdata_nxt = load_meter_select_r;
        else if (bus.addr == lrm_pkg::ADDR_LOAD_METER_RESULT_HIGH)
            rdata_nxt = {7'h00, result_r[8]};
        else if (bus.addr == lrm_pkg::ADDR_LOAD_METER_RESULT_LOW)
            rdata_nxt = result_r[7:0];
        else if (bus.addr == lrm_pkg::ADDR_LINREG_IRQ_FLAGS)
            rdata_nxt = linreg_irq_flags_r;
        else if (bus.addr == lrm_pkg::ADDR_LINREG_STATUS)
            rdata_nxt = linreg_status;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (bus.rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= 8'h00;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_start_on_write: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        wr_select |=> o_meas_start)
        else $error("select write gave no start");

    a_start_only_write: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_meas_start |-> $past(wr_select))
        else $error("start without select write");

    a_buck_follows: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        wr_select |=> o_meas_buck == $past(bus.wdata[lrm_pkg::BIT_SELECT]))
        else $error("wrong converter selected");

    a_select_stored: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        wr_select |=> load_meter_select_r
        == {7'h00, $past(bus.wdata[lrm_pkg::BIT_SELECT])})
        else $error("selector not stored");

    a_result_holds: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !meas.valid |=> $stable(result_r))
        else $error("result changed without completion");

    a_result_sum: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        meas.valid && i_buck_dual_phase && !o_meas_buck
        |=> result_r == 9'($past(i_meas_current)
        + $past(i_meas_slave_current)))
        else $error("master result is not the sum");

    a_result_slave: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        meas.valid && o_meas_buck |=> result_r == $past(i_meas_current))
        else $error("slave result is not its own current");

    a_high_read: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        bus.rd && bus.addr == lrm_pkg::ADDR_LOAD_METER_RESULT_HIGH
        |=> o_rdata == {7'h00, $past(result_r[8])})
        else $error("high result read wrong");

    a_low_read: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        bus.rd && bus.addr == lrm_pkg::ADDR_LOAD_METER_RESULT_LOW
        |=> o_rdata == $past(result_r[7:0]))
        else $error("low result read wrong");

    a_lr1_fall_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        cond_d_r[3] && !i_linreg1_pg && !linreg_irq_mask_r[7]
        |=> linreg_irq_flags_r[7])
        else $error("regulator 1 fall lost");

    a_lr1_fall_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        linreg_irq_mask_r[7] && !linreg_irq_flags_r[7]
        |=> !linreg_irq_flags_r[7])
        else $error("masked regulator 1 fall event");

    a_lr1_rise_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !cond_d_r[3] && i_linreg1_pg && !linreg_irq_mask_r[6]
        |=> linreg_irq_flags_r[6] && o_irq)
        else $error("regulator 1 rise lost");

    a_lr1_rise_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        linreg_irq_mask_r[6] && !linreg_irq_flags_r[6]
        |=> !linreg_irq_flags_r[6])
        else $error("masked regulator 1 rise event");

    a_lr1_oc_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !cond_d_r[1] && i_linreg1_overcurrent
        && !linreg_irq_mask_r[4] |=> o_linreg1_overcurrent_irq)
        else $error("regulator 1 overcurrent lost");

    a_lr1_oc_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        linreg_irq_mask_r[4] && !linreg_irq_flags_r[4]
        |=> !linreg_irq_flags_r[4])
        else $error("masked regulator 1 overcurrent event");

    a_lr0_fall_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        cond_d_r[2] && !i_linreg0_pg && !linreg_irq_mask_r[3]
        |=> o_linreg0_pg_irq)
        else $error("regulator 0 fall lost");

    a_lr0_fall_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        linreg_irq_mask_r[3] && !linreg_irq_flags_r[3]
        |=> !linreg_irq_flags_r[3])
        else $error("masked regulator 0 fall event");

    a_lr0_rise_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !cond_d_r[2] && i_linreg0_pg && !linreg_irq_mask_r[2]
        |=> linreg_irq_flags_r[2])
        else $error("regulator 0 rise lost");

    a_lr0_rise_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        linreg_irq_mask_r[2] && !linreg_irq_flags_r[2]
        |=> !linreg_irq_flags_r[2])
        else $error("masked regulator 0 rise event");

    a_lr0_oc_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !cond_d_r[0] && i_linreg0_overcurrent
        && !linreg_irq_mask_r[0] |=> linreg_irq_flags_r[0])
        else $error("regulator 0 overcurrent lost");

    a_lr0_oc_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        linreg_irq_mask_r[0] && !linreg_irq_flags_r[0]
        |=> !linreg_irq_flags_r[0])
        else $error("masked regulator 0 overcurrent event");

    a_irq_masked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        (&linreg_irq_mask_r[7:6]) && linreg_irq_mask_r[4]
        && (&linreg_irq_mask_r[3:2]) && linreg_irq_mask_r[0]
        |-> !o_irq)
        else $error("interrupt while all masked");

    a_status_track: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        bus.rd && bus.addr == lrm_pkg::ADDR_LINREG_STATUS
        |=> o_rdata[3] == $past(i_linreg1_pg))
        else $error("status does not track condition");

    a_status_low_bits: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        bus.rd && bus.addr == lrm_pkg::ADDR_LINREG_STATUS
        |=> o_rdata == {4'h0, $past(i_linreg1_pg), $past(i_linreg0_pg),
        $past(i_linreg1_overcurrent), $past(i_linreg0_overcurrent)})
        else $error("status read does not match conditions");
endmodule : lrm_top

// file: tb/lrm_meter_model.sv
// Behavioural analog load meter answering the measurement start strobe.
// Assumes one clock shared with the register bank; latency set by bench.
`timescale 1ns/1ps
module lrm_meter_model (
    input wire logic i_clock,
    input wire logic i_start,
    input wire logic i_buck,
    input wire logic [8:0] i_cur0,
    input wire logic [8:0] i_cur1,
    input wire logic [7:0] i_lat,
    output logic o_done = 1'b0,
    output logic [8:0] o_current = 9'h000,
    output logic [8:0] o_slave_current = 9'h000
);
    logic busy = 1'b0;
    logic [7:0] cnt = 8'h00;
    // Results only hold in the done cycle; otherwise the lines churn
    always_ff @(posedge i_clock)
    begin
        o_done <= 1'b0;
        o_current <= ~o_current;
        o_slave_current <= ~o_slave_current;
        if (i_start)
        begin
            busy <= 1'b1;
            cnt <= i_lat;
        end
        else if (busy && cnt == 8'h00)
        begin
            busy <= 1'b0;
            o_done <= 1'b1;
            o_current <= i_buck ? i_cur1 : i_cur0;
            o_slave_current <= i_cur1;
        end
        else if (busy)
        begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : lrm_meter_model

// file: tb/lrm_top_tb_top.sv
// Self-checking bench for the regulator mask and load meter bank.
// Assumes the meter model stands in for the analog front end.
`timescale 1ns/1ps
module lrm_top_tb_top;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    lrm_pkg::lrm_bus_s bus = '0;
    logic [3:0] cond = 4'h0;
    logic dual = 1'b0;
    logic [8:0] cur0 = 9'h000;
    logic [8:0] cur1 = 9'h000;
    logic [7:0] lat = 8'h0c;
    logic [7:0] rdata;
    logic [3:0] irqv;
    logic irq, m_start, m_buck, m_done, rd_d = 1'b0;
    logic [8:0] mcur, mslv;
    logic [7:0] q[$];
    int n_fail = 0;
    int num_checks = 0;
    integer seed = 32'h9746f94b;

    initial forever #25 i_clock = ~i_clock;

    lrm_top DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(bus.addr),
        .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .o_rdata(rdata),
        .i_linreg1_pg(cond[3]), .i_linreg0_pg(cond[2]),
        .i_linreg1_overcurrent(cond[1]), .i_linreg0_overcurrent(cond[0]),
        .i_buck_dual_phase(dual), .o_meas_start(m_start),
        .o_meas_buck(m_buck), .i_meas_done(m_done), .i_meas_current(mcur),
        .i_meas_slave_current(mslv), .o_linreg1_pg_irq(irqv[3]),
        .o_linreg0_pg_irq(irqv[2]), .o_linreg1_overcurrent_irq(irqv[1]),
        .o_linreg0_overcurrent_irq(irqv[0]), .o_irq(irq));

    lrm_meter_model meter (.i_clock(i_clock), .i_start(m_start),
        .i_buck(m_buck), .i_cur0(cur0), .i_cur1(cur1), .i_lat(lat),
        .o_done(m_done), .o_current(mcur), .o_slave_current(mslv));

    task automatic chk(input string nm, input logic [8:0] s,
        input logic [8:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_clock);
        bus.wr <= 1'b0;
    endtask : wr

    // Expected read data is queued here and compared by the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        q.push_back(e);
        @(posedge i_clock);
        bus.rd <= 1'b0;
    endtask : rd

    always @(posedge i_clock)
    begin
        if (rd_d)
            chk("rdata", {1'b0, rdata}, {1'b0, q.pop_front()});
        rd_d <= bus.rd;
    end

    // One event, masked or not; restores happen with every source masked
    task automatic ev(input int b, input int s, input logic lv, input logic m);
        wr(lrm_pkg::ADDR_LINREG_IRQ_MASK, 8'hdd);
        @(posedge i_clock);
        cond[s] <= ~lv;
        wr(lrm_pkg::ADDR_LINREG_IRQ_FLAGS, 8'hff);
        wr(lrm_pkg::ADDR_LINREG_IRQ_MASK, 8'hdd ^ (m ? 8'h00 : 8'h01 << b));
        @(posedge i_clock);
        cond[s] <= lv;
        repeat (2) @(posedge i_clock);
        #1;
        chk("irq", {8'h00, irq}, {8'h00, ~m});
        chk("irq lines", {5'h00, irqv}, m ? 9'h000 : 9'h001 << s);
        rd(lrm_pkg::ADDR_LINREG_IRQ_FLAGS,
            m ? 8'h00 : 8'h01 << b);
        rd(lrm_pkg::ADDR_LINREG_STATUS, {4'h0, cond});
    endtask : ev

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        $display("watchdog expired");
        complete_run();
    end

    initial
    begin : main
        logic [8:0] c0, c1, ex, prev;
        logic sel;
        prev = 9'h000;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int a = 8'h23; a <= 8'h28; a++)
            rd(8'(a), 8'h00);
        rd(8'h40, 8'h00);
        wr(lrm_pkg::ADDR_LINREG_IRQ_MASK, 8'hff);
        rd(lrm_pkg::ADDR_LINREG_IRQ_MASK, 8'hdd);
        $display("reset and access test done");
        for (int m = 1; m >= 0; m--)
        begin
            ev(6, 3, 1'b1, m[0]);
            ev(7, 3, 1'b0, m[0]);
            ev(4, 1, 1'b1, m[0]);
            ev(2, 2, 1'b1, m[0]);
            ev(3, 2, 1'b0, m[0]);
            ev(0, 0, 1'b1, m[0]);
        end
        $display("interrupt mask test done");
        for (int i = 0; i < 6; i++)
        begin
            sel = i[0];
            c0 = 9'({$random(seed)} % 256);
            c1 = 9'({$random(seed)} % 256);
            ex = (!sel && i[1]) ? c0 + c1 : (sel ? c1 : c0);
            @(posedge i_clock);
            cur0 <= c0;
            cur1 <= c1;
            dual <= i[1];
            lat <= 8'(10 + {$random(seed)} % 20);
            wr(lrm_pkg::ADDR_LOAD_METER_SELECT, {7'h00, sel});
            #1;
            chk("start", {8'h00, m_start}, 9'h001);
            chk("buck", {8'h00, m_buck}, {8'h00, sel});
            rd(lrm_pkg::ADDR_LOAD_METER_RESULT_HIGH,
                {7'h00, prev[8]});
            wr(lrm_pkg::ADDR_LOAD_METER_RESULT_LOW, 8'hff);
            rd(lrm_pkg::ADDR_LOAD_METER_RESULT_LOW, prev[7:0]);
            for (int k = 0; k < 200 && m_done !== 1'b1; k++)
                @(posedge i_clock);
            chk("done", {8'h00, m_done}, 9'h001);
            repeat (2) @(posedge i_clock);
            rd(lrm_pkg::ADDR_LOAD_METER_RESULT_HIGH, {7'h00, ex[8]});
            rd(lrm_pkg::ADDR_LOAD_METER_RESULT_LOW,
                ex[7:0]);
            rd(lrm_pkg::ADDR_LOAD_METER_SELECT, {7'h00, sel});
            prev = ex;
            $display("measurement case %0d done", i);
        end
        repeat (3) @(posedge i_clock);
        complete_run();
    end
endmodule : lrm_top_tb_top
